// *** rx_timeout_pkg.sv ***
// shared constants, types and helpers for the receive timeout monitor
package rx_timeout_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [4:0] PRESCALER_OFFSET   = 5'h00;
    localparam logic [4:0] COUNTER_OFFSET     = 5'h04;
    localparam logic [4:0] FILTER_OPT_OFFSET  = 5'h08;
    localparam logic [4:0] STOP_MASK_OFFSET   = 5'h0C;
    localparam logic [4:0] COMMAND_OFFSET     = 5'h10;
    localparam logic [4:0] STATUS_OFFSET      = 5'h14;
    localparam logic [4:0] TIMER_VALUE_OFFSET = 5'h18;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int AND_OR_SELECT_BIT   = 0;
    localparam int CS_MASK_BIT         = 0;
    localparam int SYNC_MASK_BIT       = 1;
    localparam int PREAMBLE_MASK_BIT   = 2;
    localparam int ABORT_CMD_BIT       = 0;
    localparam int STAT_RUNNING_BIT    = 0;
    localparam int STAT_STOPPED_BIT    = 1;
    localparam int STAT_EXPIRED_BIT    = 2;
    localparam int STAT_CS_BIT         = 3;
    localparam int STAT_SYNC_BIT       = 4;
    localparam int STAT_PREAMBLE_BIT   = 5;
    localparam int VALUE_PRESC_LSB     = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PRESCALER_RESET     = 8'h01;
    localparam logic [7:0] COUNTER_RESET       = 8'h00;
    localparam logic       AND_OR_SELECT_RESET = 1'b1;
    localparam logic [2:0] STOP_MASK_RESET     = 3'h0;

    // ------------------------------------------------------------------
    // timing: base tick of the timeout timer
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] prescaler;
        logic [7:0] counter;
        logic       and_or_select;
        logic [2:0] stop_mask;
    } timeout_cfg_t;

    typedef struct packed {
        logic cs_valid;
        logic sync_quality_valid;
        logic preamble_quality_valid;
    } quality_t;

    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_COUNT,
        TMR_HALTED,
        TMR_EXPIRED
    } timer_state_t;

    // stop condition from masks, select bit and indicators
    function automatic logic stop_condition(input timeout_cfg_t cfg, input quality_t q);
        logic [2:0] ind;
        logic [2:0] m;
        ind = {q.preamble_quality_valid, q.sync_quality_valid, q.cs_valid};
        m   = cfg.stop_mask;
        if (m == 3'h0) begin
            stop_condition = cfg.and_or_select;
        end else if (cfg.and_or_select == 1'b0) begin
            stop_condition = ((ind & m) == m);
        end else begin
            stop_condition = ((ind & m) != 3'h0);
        end
    endfunction

endpackage

// *** sync3.sv ***
// three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
module sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk_i,  // core clock
    input  wire logic             sys_rst_i,   // synchronous reset, active high
    input  wire logic [WIDTH-1:0] async_i,     // asynchronous inputs
    output logic      [WIDTH-1:0] sync_o       // filtered, synchronised outputs
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta_r   <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            meta_r   <= async_i;
            stage2_r <= meta_r;
            stage3_r <= stage2_r;
        end
    end

    // output follows once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge core_clk_i) begin
                if (sys_rst_i) begin
                    sync_o[g] <= 1'b0;
                end else if (stage2_r[g] == stage3_r[g]) begin
                    sync_o[g] <= stage3_r[g];
                end
            end
        end
    endgenerate

endmodule

// *** rx_timeout_stop_logic.sv ***
// receive window timeout timer with quality-based stop and axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module rx_timeout_stop_logic
    import rx_timeout_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic        core_clk_i,               // core clock, 40 MHz
    input  wire logic        sys_rst_i,                // synchronous reset, active high
    input  wire logic        rx_active_i,              // receive state, same clock
    input  wire logic        cs_valid_i,               // carrier sense valid, async
    input  wire logic        sync_quality_valid_i,     // sync quality valid, async
    input  wire logic        preamble_quality_valid_i, // preamble quality valid, async
    output logic             rx_abort_o,               // abort reception pulse
    output logic             packet_discard_o,         // discard packet pulse
    output logic             abort_command_o,          // software abort pulse
    output logic             timer_running_o,          // timer counting
    output logic             timer_stopped_o,          // timer halted by stop condition
    input  wire logic [4:0]  s_axi_awaddr,             // write address
    input  wire logic        s_axi_awvalid,            // write address valid
    output logic             s_axi_awready,            // write address ready
    input  wire logic [31:0] s_axi_wdata,              // write data
    input  wire logic [3:0]  s_axi_wstrb,              // write strobes
    input  wire logic        s_axi_wvalid,             // write data valid
    output logic             s_axi_wready,             // write data ready
    output logic [1:0]       s_axi_bresp,              // write response
    output logic             s_axi_bvalid,             // write response valid
    input  wire logic        s_axi_bready,             // write response ready
    input  wire logic [4:0]  s_axi_araddr,             // read address
    input  wire logic        s_axi_arvalid,            // read address valid
    output logic             s_axi_arready,            // read address ready
    output logic [31:0]      s_axi_rdata,              // read data
    output logic [1:0]       s_axi_rresp,              // read response
    output logic             s_axi_rvalid,             // read data valid
    input  wire logic        s_axi_rready              // read data ready
);

    // ------------------------------------------------------------------
    // configuration and state
    // ------------------------------------------------------------------
    timeout_cfg_t cfg_r;
    quality_t     quality;
    logic [2:0]   quality_sync;
    timer_state_t state_r;
    timer_state_t state_nxt;
    logic [7:0]   count_r;
    logic [7:0]   presc_cnt_r;
    logic         expired_flag_r;
    logic         expire_evt;
    logic         stop_now;
    logic         tick_r;
    logic [$clog2(TICK_DIV+1)-1:0] div_cnt_r;

    // ------------------------------------------------------------------
    // indicator synchronisers
    // ------------------------------------------------------------------
    sync3 #(
        .WIDTH (3)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    ({preamble_quality_valid_i, sync_quality_valid_i, cs_valid_i}),
        .sync_o     (quality_sync)
    );

    assign quality = '{cs_valid:               quality_sync[0],
                       sync_quality_valid:     quality_sync[1],
                       preamble_quality_valid: quality_sync[2]};

    // masks, select and indicators combine per the stop table
    assign stop_now = stop_condition(cfg_r, quality);

    // ------------------------------------------------------------------
    // base tick divider
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i || state_r == TMR_IDLE) begin
            div_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else if (div_cnt_r == ($clog2(TICK_DIV+1))'(TICK_DIV - 1)) begin
            div_cnt_r <= '0;
            tick_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
            tick_r    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // timeout state machine
    // ------------------------------------------------------------------
    assign expire_evt = (state_r == TMR_COUNT) && tick_r && !stop_now &&
                        (presc_cnt_r == cfg_r.prescaler) && (count_r == 8'h01);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TMR_IDLE: begin
                if (rx_active_i) begin
                    state_nxt = TMR_COUNT;
                end
            end
            TMR_COUNT: begin
                if (!rx_active_i) begin
                    state_nxt = TMR_IDLE;
                end else if (stop_now) begin
                    state_nxt = TMR_HALTED;
                end else if (expire_evt) begin
                    state_nxt = TMR_EXPIRED;
                end
            end
            TMR_HALTED: begin
                // stays halted; software abort leaves receive otherwise
                if (!rx_active_i) begin
                    state_nxt = TMR_IDLE;
                end
            end
            TMR_EXPIRED: begin
                if (!rx_active_i) begin
                    state_nxt = TMR_IDLE;
                end
            end
            default: state_nxt = TMR_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_r <= TMR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // window length = counter x (prescaler + 1) base ticks
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            count_r     <= 8'h00;
            presc_cnt_r <= 8'h00;
        end else if (state_r == TMR_IDLE) begin
            count_r     <= cfg_r.counter;
            presc_cnt_r <= 8'h00;
        end else if (state_r == TMR_COUNT && tick_r && !stop_now && count_r != 8'h00) begin
            if (presc_cnt_r == cfg_r.prescaler) begin
                presc_cnt_r <= 8'h00;
                count_r     <= count_r - 8'h01;
            end else begin
                presc_cnt_r <= presc_cnt_r + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rx_abort_o       <= 1'b0;
            packet_discard_o <= 1'b0;
        end else begin
            rx_abort_o       <= expire_evt;
            packet_discard_o <= expire_evt;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            timer_running_o <= 1'b0;
            timer_stopped_o <= 1'b0;
        end else begin
            timer_running_o <= (state_nxt == TMR_COUNT);
            timer_stopped_o <= (state_nxt == TMR_HALTED);
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    logic [4:0]  wr_addr_r;
    logic [31:0] wr_data_r;
    logic        wr_strb0_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic        wr_go;
    logic        status_clear;

    assign wr_go        = aw_held_r && w_held_r && !s_axi_bvalid;
    assign status_clear = wr_go && wr_strb0_r && (wr_addr_r == STATUS_OFFSET) &&
                          wr_data_r[STAT_EXPIRED_BIT];

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_awready <= 1'b1;
            aw_held_r     <= 1'b0;
            wr_addr_r     <= 5'h00;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_held_r     <= 1'b1;
            wr_addr_r     <= {s_axi_awaddr[4:2], 2'b00};
        end else if (wr_go) begin
            s_axi_awready <= 1'b1;
            aw_held_r     <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_wready <= 1'b1;
            w_held_r     <= 1'b0;
            wr_data_r    <= 32'h0000_0000;
            wr_strb0_r   <= 1'b0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_held_r     <= 1'b1;
            wr_data_r    <= s_axi_wdata;
            wr_strb0_r   <= s_axi_wstrb[0];
        end else if (wr_go) begin
            s_axi_wready <= 1'b1;
            w_held_r     <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            if (wr_addr_r <= TIMER_VALUE_OFFSET) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers, low byte lane only
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cfg_r.prescaler     <= PRESCALER_RESET;
            cfg_r.counter       <= COUNTER_RESET;
            cfg_r.and_or_select <= AND_OR_SELECT_RESET;
            cfg_r.stop_mask     <= STOP_MASK_RESET;
        end else if (wr_go && wr_strb0_r) begin
            if (wr_addr_r == PRESCALER_OFFSET) begin
                cfg_r.prescaler <= wr_data_r[7:0];
            end else if (wr_addr_r == COUNTER_OFFSET) begin
                cfg_r.counter <= wr_data_r[7:0];
            end else if (wr_addr_r == FILTER_OPT_OFFSET) begin
                cfg_r.and_or_select <= wr_data_r[AND_OR_SELECT_BIT];
            end else if (wr_addr_r == STOP_MASK_OFFSET) begin
                cfg_r.stop_mask <= wr_data_r[2:0];
            end
        end
    end

    // software abort pulse
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            abort_command_o <= 1'b0;
        end else begin
            abort_command_o <= wr_go && wr_strb0_r && (wr_addr_r == COMMAND_OFFSET) &&
                               wr_data_r[ABORT_CMD_BIT];
        end
    end

    // sticky expiry flag, set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            expired_flag_r <= 1'b0;
        end else if (expire_evt) begin
            expired_flag_r <= 1'b1;
        end else if (status_clear) begin
            expired_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    logic [4:0] rd_addr;

    assign rd_addr = {s_axi_araddr[4:2], 2'b00};

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (rd_addr == PRESCALER_OFFSET) begin
                s_axi_rdata[7:0] <= cfg_r.prescaler;
            end else if (rd_addr == COUNTER_OFFSET) begin
                s_axi_rdata[7:0] <= cfg_r.counter;
            end else if (rd_addr == FILTER_OPT_OFFSET) begin
                s_axi_rdata[AND_OR_SELECT_BIT] <= cfg_r.and_or_select;
            end else if (rd_addr == STOP_MASK_OFFSET) begin
                s_axi_rdata[2:0] <= cfg_r.stop_mask;
            end else if (rd_addr == COMMAND_OFFSET) begin
                s_axi_rdata <= 32'h0000_0000;
            end else if (rd_addr == STATUS_OFFSET) begin
                s_axi_rdata[STAT_RUNNING_BIT]  <= (state_r == TMR_COUNT);
                s_axi_rdata[STAT_STOPPED_BIT]  <= (state_r == TMR_HALTED);
                s_axi_rdata[STAT_EXPIRED_BIT]  <= expired_flag_r;
                s_axi_rdata[STAT_CS_BIT]       <= quality.cs_valid;
                s_axi_rdata[STAT_SYNC_BIT]     <= quality.sync_quality_valid;
                s_axi_rdata[STAT_PREAMBLE_BIT] <= quality.preamble_quality_valid;
            end else if (rd_addr == TIMER_VALUE_OFFSET) begin
                s_axi_rdata[7:0]                  <= count_r;
                s_axi_rdata[VALUE_PRESC_LSB +: 8] <= presc_cnt_r;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// *** rx_timeout_sva.sv ***
// checker for the receive timeout monitor ports
`timescale 1ns/1ps
module rx_timeout_sva
    import rx_timeout_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic        core_clk_i,       // core clock
    input wire logic        sys_rst_i,        // reset
    input wire logic        rx_active_i,      // receive state
    input wire logic        rx_abort_o,       // abort pulse
    input wire logic        packet_discard_o, // discard pulse
    input wire logic        abort_command_o,  // software abort
    input wire logic        timer_running_o,  // counting
    input wire logic        timer_stopped_o,  // halted
    input wire logic        s_axi_arvalid,    // read address valid
    input wire logic        s_axi_arready,    // read address ready
    input wire logic        s_axi_rvalid,     // read data valid
    input wire logic        s_axi_rready,     // read data ready
    input wire logic [31:0] s_axi_rdata,      // read data
    input wire logic        s_axi_bvalid,     // write response valid
    input wire logic        s_axi_bready      // write response ready
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    abort_discard_a: assert property (rx_abort_o == packet_discard_o)
        else $error("abort and discard differ");
    abort_pulse_a: assert property (rx_abort_o |=> !rx_abort_o)
        else $error("abort longer than one cycle");
    abort_cause_a: assert property (rx_abort_o |-> $past(timer_running_o) && !timer_running_o)
        else $error("abort without running timer");
    run_stop_excl_a: assert property (!(timer_running_o && timer_stopped_o))
        else $error("running and stopped together");
    stop_latch_a: assert property (timer_stopped_o && rx_active_i |=> timer_stopped_o)
        else $error("stop released in receive");
    idle_quiet_a: assert property (!rx_active_i [*2] |=> !timer_running_o && !rx_abort_o)
        else $error("timer active outside receive");
    cmd_pulse_a: assert property (abort_command_o |=> !abort_command_o)
        else $error("abort command not a pulse");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    cover property (rx_abort_o);
    cover property ($rose(timer_stopped_o));
    cover property (abort_command_o);
endmodule
bind rx_timeout_stop_logic rx_timeout_sva #(.TICK_DIV(TICK_DIV)) rx_timeout_sva_i (.*);

// *** rf_sender_model.sv ***
// far-side sender: quality indicators seen by the receiver
`timescale 1ns/1ps
module rf_sender_model (
    input  wire logic       core_clk_i,   // clock
    input  wire logic [2:0] air_i,        // preamble, sync, carrier
    output logic            cs_o,         // carrier sense valid
    output logic            sync_o,       // sync quality valid
    output logic            preamble_o    // preamble quality valid
);
    always_ff @(posedge core_clk_i) begin
        {preamble_o, sync_o, cs_o} <= air_i;
    end
endmodule

// *** test_rx_timeout_stop_logic.sv ***
// self-checking bench for the receive timeout monitor
`timescale 1ns/1ps
module test_rx_timeout_stop_logic;
    import rx_timeout_pkg::*;
    localparam int TD = 2;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        rx = 1'h0;
    logic [2:0]  air = 3'h0;
    logic        cs, sq, pq, abrt, disc, cmd, run, stp;
    logic [4:0]  awaddr = 5'h00;
    logic [4:0]  araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    int          n_errors = 0;
    int          n_checks = 0;
    // {expect stop, select, mask[2:0], indicators[2:0]}
    logic [7:0]  tbl [9] = '{8'h89, 8'h48, 8'h19, 8'h9B, 8'hF4, 8'h71, 8'hBF, 8'h07, 8'hC0};

    rx_timeout_stop_logic #(.TICK_DIV(TD)) rx_timeout_stop_logic_i (
        .core_clk_i(clk), .sys_rst_i(rst), .rx_active_i(rx), .cs_valid_i(cs),
        .sync_quality_valid_i(sq), .preamble_quality_valid_i(pq), .rx_abort_o(abrt),
        .packet_discard_o(disc), .abort_command_o(cmd), .timer_running_o(run), .timer_stopped_o(stp),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    rf_sender_model rf_sender_model_i (.core_clk_i(clk), .air_i(air), .cs_o(cs), .sync_o(sq), .preamble_o(pq));

    initial begin
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid && n < 50);
        r = bresp;
        bready <= 1'h0;
        if (n >= 50) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid && n < 50);
        {d, r} = {rdata, rresp};
        rready <= 1'h0;
        if (n >= 50) begin
            n_errors++;
            summarize();
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        rd(PRESCALER_OFFSET, d, r);
        chk(d, 32'(PRESCALER_RESET));
        rd(FILTER_OPT_OFFSET, d, r);
        chk(d, 32'(AND_OR_SELECT_RESET));
        rd(STOP_MASK_OFFSET, d, r);
        chk(d, 32'(STOP_MASK_RESET));
        rd(5'h1C, d, r);
        chk({30'h0, r}, 32'(RESP_SLVERR));
        wr(5'h1C, 32'h1, r);
        chk({30'h0, r}, 32'(RESP_SLVERR));
    endtask
    task automatic t_expire;
        int n;
        logic [1:0] r;
        logic ran;
        logic [31:0] d;
        wr(PRESCALER_OFFSET, 32'h1, r);
        wr(COUNTER_OFFSET, 32'h3, r);
        rd(COUNTER_OFFSET, d, r);
        chk(d, 32'h3);
        wr(FILTER_OPT_OFFSET, 32'h0, r);
        wr(STOP_MASK_OFFSET, 32'h0, r);
        @(posedge clk);
        rx <= 1'h1;
        n = 0;
        ran = 1'h0;
        do begin
            @(posedge clk);
            n++;
            ran |= run;
        end while (!abrt && n < 200);
        chk({31'h0, disc}, 32'h1);
        chk({31'h0, n >= 5 * TD && n <= 8 * TD + 2}, 32'h1);
        chk({31'h0, ran}, 32'h1);
        chk({31'h0, run}, 32'h0);
        if (n >= 200) summarize();
        @(posedge clk);
        rx <= 1'h0;
        cyc(3);
        rd(STATUS_OFFSET, d, r);
        chk(d, 32'h1 << STAT_EXPIRED_BIT);
        wr(STATUS_OFFSET, 32'h1 << STAT_EXPIRED_BIT, r);
        rd(STATUS_OFFSET, d, r);
        chk(d, 32'h0);
    endtask
    task automatic t_stops;
        logic [7:0] c;
        logic st, ab;
        logic [1:0] r;
        wr(PRESCALER_OFFSET, 32'h0, r);
        wr(COUNTER_OFFSET, 32'h3, r);
        for (int i = 0; i < 9; i++) begin
            c = tbl[i];
            wr(FILTER_OPT_OFFSET, {31'h0, c[6]}, r);
            wr(STOP_MASK_OFFSET, {29'h0, c[5:3]}, r);
            air <= c[2:0];
            cyc(8);
            rx <= 1'h1;
            {st, ab} = 2'h0;
            repeat (40) begin
                @(posedge clk);
                st |= stp;
                ab |= abrt;
            end
            chk({31'h0, st}, {31'h0, c[7]});
            chk({31'h0, ab}, {31'h0, ~c[7]});
            rx <= 1'h0;
            air <= 3'h0;
            cyc(3);
        end
    endtask
    task automatic t_cmd;
        logic seen;
        logic [1:0] r;
        wr(COMMAND_OFFSET, 32'h1, r);
        seen = cmd;
        repeat (5) begin
            @(posedge clk);
            seen |= cmd;
        end
        chk({31'h0, seen}, 32'h1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_expire();
        t_stops();
        t_cmd();
        summarize();
    end
endmodule
